/* File: core/fcsm_host.sv */
// Purpose: host controller issuing command sequences to an async NOR flash
// Assumes: flash pins are synchronous to mclk at the controller side
// Notes: one sequence at a time; polls poll bit for completion
//
// Contract
// - timeout flag high: host writes reset
// - reset exits identification mode
// - two unlocks plus identification command
// - program: two unlocks, setup, address data
// - hardware reset aborts program, repeat it
// - bypass: unlocks plus 20h, then A0h writes
// - bypass exit: 90h then 00h
// - chip erase takes six writes
`include "fcsm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fcsm_host
   import fcsm_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [3:0] regAddr, // register index
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata, // valid cycle after regRd
   output logic [19:0] flashAddr,
   output logic [15:0] flashDqOut,
   output logic flashDqOe, // high while host drives data
   input wire logic [15:0] flashDqIn,
   output logic flashCeN,
   output logic flashWeN,
   output logic flashOeN,
   output logic flashResetN, // hardware reset to flash
   output logic flashByteN, // low selects byte width
   input wire logic flashReadyBusyN
);
   // ==========================================
   // state machine
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_WSETUP = 6'b000010, // address out, we still high
      S_WPULSE = 6'b000100, // we low
      S_WHOLD = 6'b001000, // we high, data held
      S_RPULSE = 6'b010000, // oe low, waiting access
      S_POLL = 6'b100000 // waiting algorithm end
   } fcsm_st_e;
   fcsm_st_e st, next_st;
   fcsm_cycle_s seq [0:5]; // sequence of bus cycles
   logic [2:0] idx, next_idx, seqLen;
   logic [3:0] cnt, next_cnt;
   logic [19:0] cmdAddr; // target address register
   logic [15:0] cmdData; // program data register
   logic byteMode; // width select, steers byte pin
   logic busy, next_busy, doPoll, next_doPoll, isRead, next_isRead, errTo, next_errTo;
   logic [15:0] rdData, next_rdData;
   logic [2:0] rdySync; // ready pin synchroniser
   logic rdyStable;
   fcsm_op_e op, next_op;
   fcsm_op_e opSel; // operation the next bus cycle belongs to
   // ==========================================
   // sequence builder, from command table values
   function automatic fcsm_cycle_s unl(input logic second);
      unl.addr = second ? `FCSM_UNLOCK2_ADDR : `FCSM_UNLOCK1_ADDR;
      unl.data = second ? `FCSM_UNLOCK2_DATA : `FCSM_UNLOCK1_DATA;
   endfunction
   // the first cycle loads before op registers, so pick the incoming order
   always_comb begin
      if (st == S_IDLE) begin
         opSel = fcsm_op_e'(regWdata[3:0]);
      end else if (st == S_POLL) begin
         opSel = FCSM_OP_RESET; // only a timeout leaves poll for a write
      end else begin
         opSel = op;
      end
      for (int i = 0; i < 6; i++) begin
         seq[i] = '{addr: cmdAddr, data: `FCSM_CMD_RESET};
      end
      seqLen = 3'd1;
      seq[0] = unl(1'b0);
      seq[1] = unl(1'b1);
      case (opSel)
         FCSM_OP_RESET: begin // also exits identification
            seq[0] = '{addr: cmdAddr, data: `FCSM_CMD_RESET};
            seqLen = 3'd1;
         end
         FCSM_OP_IDENT: begin
            seq[2] = '{addr: `FCSM_UNLOCK1_ADDR, data: `FCSM_CMD_IDENT};
            seqLen = 3'd3;
         end
         FCSM_OP_PROG: begin // four writes
            seq[2] = '{addr: `FCSM_UNLOCK1_ADDR, data: `FCSM_CMD_PROG};
            seq[3] = '{addr: cmdAddr, data: cmdData};
            seqLen = 3'd4;
         end
         FCSM_OP_BYP_ENTER: begin
            seq[2] = '{addr: `FCSM_UNLOCK1_ADDR, data: `FCSM_CMD_BYPASS};
            seqLen = 3'd3;
         end
         FCSM_OP_BYP_PROG: begin // one of two valid bypass commands
            seq[0] = '{addr: cmdAddr, data: `FCSM_CMD_PROG};
            seq[1] = '{addr: cmdAddr, data: cmdData};
            seqLen = 3'd2;
         end
         FCSM_OP_BYP_EXIT: begin // 90h then 00h, any address
            seq[0] = '{addr: cmdAddr, data: `FCSM_CMD_IDENT};
            seq[1] = '{addr: cmdAddr, data: `FCSM_CMD_BYPASS_EXIT2};
            seqLen = 3'd2;
         end
         FCSM_OP_CHIP_ERASE: begin // six writes
            seq[2] = '{addr: `FCSM_UNLOCK1_ADDR, data: `FCSM_CMD_ERASE_SETUP};
            seq[3] = unl(1'b0);
            seq[4] = unl(1'b1);
            seq[5] = '{addr: `FCSM_UNLOCK1_ADDR, data: `FCSM_CMD_CHIP_ERASE};
            seqLen = 3'd6;
         end
         default: begin // array read needs no command
            seqLen = 3'd0;
         end
      endcase
   end
   // ==========================================
   // ready pin synchroniser, third and second must agree
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdySync <= 3'b111;
         rdyStable <= 1'b1;
      end else begin
         rdySync <= {rdySync[1:0], flashReadyBusyN};
         if (rdySync[1] == rdySync[2]) begin
            rdyStable <= rdySync[2];
         end
      end
   end
   // ==========================================
   // sequencer next state
   always_comb begin
      next_st = st;
      next_idx = idx;
      next_cnt = cnt;
      next_busy = busy;
      next_doPoll = doPoll;
      next_isRead = isRead;
      next_errTo = errTo;
      next_rdData = rdData;
      next_op = op;
      case (st)
         S_IDLE: begin
            if (regWr && regAddr == `FCSM_REG_CMD && !busy) begin
               next_op = fcsm_op_e'(regWdata[3:0]);
               next_idx = 3'd0;
               next_cnt = 4'd0;
               next_busy = 1'b1;
               next_errTo = 1'b0;
               next_isRead = (regWdata[3:0] == FCSM_OP_READ);
               // program and erase poll for the end
               next_doPoll = (regWdata[3:0] == FCSM_OP_PROG) ||
                  (regWdata[3:0] == FCSM_OP_BYP_PROG) ||
                  (regWdata[3:0] == FCSM_OP_CHIP_ERASE);
               next_st = (regWdata[3:0] == FCSM_OP_READ) ? S_RPULSE : S_WSETUP;
            end
         end
         S_WSETUP: begin // address settles before we falls; ce is already low
            next_st = S_WPULSE;
            next_cnt = 4'd0;
         end
         S_WPULSE: begin
            next_cnt = cnt + 4'd1;
            if (cnt == 4'(`FCSM_PULSE_CYC - 1)) begin
               next_st = S_WHOLD;
            end
         end
         S_WHOLD: begin // data held past the rising we; ce stays low
            next_idx = idx + 3'd1;
            if (idx + 3'd1 < seqLen) begin
               next_st = S_WSETUP;
            end else if (doPoll) begin
               next_st = S_POLL; // no writes while algorithm runs
               next_cnt = 4'd0;
            end else begin
               next_st = S_IDLE;
               next_busy = 1'b0;
            end
         end
         S_RPULSE: begin
            next_cnt = cnt + 4'd1;
            if (cnt == 4'(`FCSM_ACCESS_CYC)) begin
               next_rdData = flashDqIn;
               if (isRead) begin
                  next_st = S_IDLE;
                  next_busy = 1'b0;
               end else begin
                  next_st = S_POLL;
               end
            end
         end
         S_POLL: begin // poll bit equals data when done
            next_cnt = 4'd0;
            if (flashDqIn[`FCSM_POLL_BIT] == cmdData[`FCSM_POLL_BIT] && rdyStable) begin
               next_st = S_IDLE;
               next_busy = 1'b0;
            end else if (flashDqIn[`FCSM_TIMEOUT_BIT]) begin
               // timeout flag: recover with reset command
               next_errTo = 1'b1;
               next_op = FCSM_OP_RESET;
               next_doPoll = 1'b0;
               next_idx = 3'd0;
               next_st = S_WSETUP;
            end
         end
         default: begin
            next_st = S_IDLE;
         end
      endcase
   end
   // ==========================================
   // sequencer registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st <= S_IDLE;
         idx <= 3'd0;
         cnt <= 4'd0;
         busy <= 1'b0;
         doPoll <= 1'b0;
         isRead <= 1'b0;
         errTo <= 1'b0;
         rdData <= 16'h0000;
         op <= FCSM_OP_READ;
      end else begin
         st <= next_st;
         idx <= next_idx;
         cnt <= next_cnt;
         busy <= next_busy;
         doPoll <= next_doPoll;
         isRead <= next_isRead;
         errTo <= next_errTo;
         rdData <= next_rdData;
         op <= next_op;
      end
   end
   // ==========================================
   // software registers and flash pins
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cmdAddr <= 20'h00000;
         cmdData <= 16'hFFFF;
         byteMode <= 1'b0;
         regRdata <= 32'h00000000;
         flashAddr <= 20'h00000;
         flashDqOut <= 16'h0000;
         flashDqOe <= 1'b0;
         flashCeN <= 1'b1;
         flashWeN <= 1'b1;
         flashOeN <= 1'b1;
         flashResetN <= 1'b0; // held low, aborts any program
         flashByteN <= 1'b1;
      end else begin
         flashResetN <= 1'b1;
         if (regWr && !busy) begin
            if (regAddr == `FCSM_REG_ADDR) begin
               cmdAddr <= regWdata[19:0];
            end
            if (regAddr == `FCSM_REG_DATA) begin
               cmdData <= regWdata[15:0];
               byteMode <= regWdata[16]; // width select
            end
         end
         regRdata <= 32'h00000000;
         if (regRd) begin
            case (regAddr)
               `FCSM_REG_ADDR: regRdata <= {12'h000, cmdAddr};
               `FCSM_REG_DATA: regRdata <= {15'h0000, byteMode, cmdData};
               `FCSM_REG_STATUS: regRdata <= {29'h00000000, rdyStable, errTo, busy};
               `FCSM_REG_RDATA: regRdata <= {16'h0000, rdData}; // id codes
               default: regRdata <= 32'h00000000;
            endcase
         end
         flashByteN <= !byteMode;
         flashCeN <= !(next_st != S_IDLE);
         flashWeN <= !(next_st == S_WPULSE);
         flashOeN <= !(next_st == S_RPULSE || next_st == S_POLL);
         flashDqOe <= (next_st == S_WSETUP || next_st == S_WPULSE || next_st == S_WHOLD);
         if (next_st == S_WSETUP) begin
            flashAddr <= seq[next_idx].addr;
            flashDqOut <= seq[next_idx].data;
         end else if (next_st == S_RPULSE && st == S_IDLE) begin
            flashAddr <= cmdAddr;
         end
      end
   end
   // ==========================================
   // checks
   property p_write_len;
      @(posedge mclk) disable iff (reset)
         (st == S_IDLE && next_st == S_WSETUP && next_op == FCSM_OP_PROG) |=>
         (st == S_WSETUP)[*1] ##1 (st == S_WPULSE)[*3];
   endproperty
   a_write_len: assert property (p_write_len) else $error("write pulse length wrong");
   property p_prog_polls;
      @(posedge mclk) disable iff (reset)
         (st == S_WHOLD && doPoll && idx + 3'd1 >= seqLen) |=> (st == S_POLL);
   endproperty
   a_prog_polls: assert property (p_prog_polls) else $error("no poll after program");
   property p_no_write_poll;
      @(posedge mclk) disable iff (reset)
         (st == S_POLL) |-> flashWeN && !flashDqOe;
   endproperty
   a_no_write_poll: assert property (p_no_write_poll) else $error("write during algorithm");
   property p_timeout_reset;
      @(posedge mclk) disable iff (reset)
         (st == S_POLL && next_errTo && !errTo) |=> ##1 (flashDqOut == `FCSM_CMD_RESET);
   endproperty
   a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on timeout");
   property p_byp_first;
      @(posedge mclk) disable iff (reset)
         (st == S_IDLE && next_st == S_WSETUP && next_op == FCSM_OP_BYP_PROG) |=>
         (flashDqOut == `FCSM_CMD_PROG);
   endproperty
   a_byp_first: assert property (p_byp_first) else $error("bypass program not first");
   property p_read_pins;
      @(posedge mclk) disable iff (reset)
         (st == S_RPULSE) |-> !flashCeN && !flashOeN && !flashDqOe && flashWeN;
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("read strobes wrong");
endmodule
`default_nettype wire

/* File: core/fcsm_defines.svh */
// Purpose: constants for the flash command sequencer host controller
// Assumes: word-mode unlock addresses, 16-bit data path
// Notes: header holds definitions only
`ifndef FCSM_DEFINES_SVH
`define FCSM_DEFINES_SVH
// ==========================================
// register offsets of the controller
`define FCSM_REG_CMD 4'h0
`define FCSM_REG_ADDR 4'h1
`define FCSM_REG_DATA 4'h2
`define FCSM_REG_STATUS 4'h3
`define FCSM_REG_RDATA 4'h4
// ==========================================
// command table values
`define FCSM_UNLOCK1_ADDR 20'h00555
`define FCSM_UNLOCK2_ADDR 20'h002AA
`define FCSM_UNLOCK1_DATA 16'h00AA
`define FCSM_UNLOCK2_DATA 16'h0055
`define FCSM_CMD_RESET 16'h00F0
`define FCSM_CMD_IDENT 16'h0090
`define FCSM_CMD_PROG 16'h00A0
`define FCSM_CMD_BYPASS 16'h0020
`define FCSM_CMD_ERASE_SETUP 16'h0080
`define FCSM_CMD_CHIP_ERASE 16'h0010
`define FCSM_CMD_BYPASS_EXIT2 16'h0000
`define FCSM_POLL_BIT 7
`define FCSM_TIMEOUT_BIT 5
// ==========================================
// bus timing, cycles of mclk (20 ns)
`define FCSM_T_ACCESS_NS 55
`define FCSM_ACCESS_CYC ((`FCSM_T_ACCESS_NS + 19) / 20)
`define FCSM_PULSE_CYC 3
`endif

/* File: core/fcsm_pkg.sv */
// Purpose: types of the flash command sequencer host controller
// Assumes: fcsm_defines.svh is on the include path
// Notes: operation codes written to the command register
package fcsm_pkg;
   // ==========================================
   // operations software can order
   typedef enum logic [3:0] {
      FCSM_OP_READ = 4'h0,
      FCSM_OP_RESET = 4'h1,
      FCSM_OP_IDENT = 4'h2,
      FCSM_OP_PROG = 4'h3,
      FCSM_OP_BYP_ENTER = 4'h4,
      FCSM_OP_BYP_PROG = 4'h5,
      FCSM_OP_BYP_EXIT = 4'h6,
      FCSM_OP_CHIP_ERASE = 4'h7
   } fcsm_op_e;
   // one bus cycle to the flash
   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] data;
   } fcsm_cycle_s;
endpackage

/* File: verif/fcsm_flash_model.sv */
// Purpose: behavioural flash device facing the host controller
// Assumes: word-mode unlock addresses, tiny array aliased on addr[3:0]
// Notes: failMode from the bench forces a stuck timeout flag
`include "fcsm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fcsm_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h0B3C, // arbitrary value
   parameter logic [15:0] CONT_CODE = 16'h007F, // arbitrary value
   parameter int PROG_NS = 400,
   parameter int ERASE_NS = 2000
) (
   input wire logic [19:0] addr,
   input wire logic [15:0] dq, // host write data
   input wire logic ceN,
   input wire logic weN,
   input wire logic oeN,
   input wire logic resetN,
   input wire logic byteN,
   input wire logic guardN, // low guards the boot sector
   input wire logic failMode,
   output logic [15:0] dqIn,
   output logic readyBusyN
);
   typedef enum {IDLE, U1, U2, PROG, E3, E4, E5, IDENT, BYP, BPROG, BEXIT} fcsm_mst_e;
   fcsm_mst_e st = IDLE; // wakes in array read
   logic [15:0] mem [0:15];
   logic [19:0] la; // latched address
   logic [15:0] pd; // target data, drives the poll bit
   logic [15:0] val;
   logic [15:0] lastV = 16'h0000;
   logic busy = 1'b0;
   int gen = 0; // bumps to cancel a running algorithm
   int dur = 0;
   wire act = !ceN && !weN;
   initial foreach (mem[i]) mem[i] = 16'hFFFF;
   assign readyBusyN = !busy;
   // ==========================================
   // strobes: address on later fall, data on earlier rise
   always @(posedge act) la = addr;
   always @(negedge act) if (resetN === 1'b1) decode(la, byteN ? dq : {8'hFF, dq[7:0]});
   task automatic start(input int ns, input fcsm_mst_e after);
      busy = 1'b1;
      dur = ns;
      st = after;
   endtask
   task automatic decode(input logic [19:0] a, input logic [15:0] d);
      logic ok1, ok2;
      ok1 = a == `FCSM_UNLOCK1_ADDR && d == `FCSM_UNLOCK1_DATA;
      ok2 = a == `FCSM_UNLOCK2_ADDR && d == `FCSM_UNLOCK2_DATA;
      if (busy) begin
         // a stuck algorithm only yields to reset
         if (failMode && d == `FCSM_CMD_RESET) begin
            busy = 1'b0;
            gen++;
            st = IDLE;
         end
         return;
      end
      if (d == `FCSM_CMD_RESET && st != BYP && st != BPROG) begin
         st = IDLE;
         return;
      end
      case (st)
         IDLE: st = ok1 ? U1 : IDLE;
         U1: st = ok2 ? U2 : IDLE;
         U2: begin
            st = IDLE;
            if (a == `FCSM_UNLOCK1_ADDR) begin
               if (d == `FCSM_CMD_IDENT) st = IDENT;
               if (d == `FCSM_CMD_PROG) st = PROG;
               if (d == `FCSM_CMD_BYPASS) st = BYP;
               if (d == `FCSM_CMD_ERASE_SETUP) st = E3;
            end
         end
         E3: st = ok1 ? E4 : IDLE;
         E4: st = ok2 ? E5 : IDLE;
         E5: begin
            st = IDLE;
            if (a == `FCSM_UNLOCK1_ADDR && d == `FCSM_CMD_CHIP_ERASE) begin
               foreach (mem[i]) mem[i] = 16'hFFFF;
               pd = 16'hFFFF;
               start(ERASE_NS, IDLE);
            end
         end
         PROG, BPROG: begin
            // clears bits only; a stuck run leaves the cell alone
            if (!failMode) mem[a[3:0]] &= d;
            pd = d;
            start(PROG_NS, st == BPROG ? BYP : IDLE);
         end
         BYP: st = d == `FCSM_CMD_PROG ? BPROG : d == `FCSM_CMD_IDENT ? BEXIT : BYP;
         BEXIT: st = d == `FCSM_CMD_BYPASS_EXIT2 ? IDLE : BYP;
         default: ; // identification holds until reset
      endcase
   endtask
   // ==========================================
   // embedded algorithm timer, cancelled by hardware reset
   always @(posedge busy) begin : run
      int g;
      g = gen;
      #(dur);
      if (g == gen && !failMode) busy = 1'b0;
   end
   always @(negedge resetN) begin
      gen++;
      busy = 1'b0;
      st = IDLE;
   end
   // ==========================================
   // read path: status while busy, codes in identification
   always_comb begin
      if (busy) val = {8'h00, ~pd[7], 1'b0, failMode, 5'h00};
      else if (st == IDENT) begin
         case (addr[7:0])
            8'h00: val = MFR_CODE;
            8'h01: val = DEV_CODE;
            8'h11: val = CONT_CODE;
            8'h02: val = {15'h0000, addr[19:15] == 5'h1F && !guardN};
            default: val = 16'h0000;
         endcase
      end else val = mem[addr[3:0]];
   end
   // released bus shows no stale value
   assign dqIn = (!ceN && !oeN) ? val : ~lastV;
   always @(posedge oeN) lastV = val;
endmodule
`default_nettype wire

/* File: verif/tb_fcsm_host.sv */
// Purpose: register-level bench of the flash host controller
// Assumes: flash model answers within 2000 ns (chip erase), 400 ns for program
// Notes: codes below are arbitrary and fed to the model
`include "fcsm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_fcsm_host
   import fcsm_pkg::*;
;
   localparam logic [15:0] MFR = 16'h00A5; // arbitrary value
   localparam logic [15:0] DEV = 16'h0B3C; // arbitrary value
   localparam logic [15:0] CONT = 16'h007F; // arbitrary value
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic guardN = 1'b1;
   logic failMode = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0, regRdata, rv;
   logic [19:0] flashAddr;
   logic [15:0] flashDqOut, flashDqIn;
   logic flashDqOe, flashCeN, flashWeN, flashOeN, flashResetN, flashByteN, flashReadyBusyN;
   int n_errors = 0;
   int check_count = 0;
   always #10 mclk = ~mclk;
   fcsm_host dut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr),
      .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
      .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
      .flashResetN(flashResetN), .flashByteN(flashByteN), .flashReadyBusyN(flashReadyBusyN));
   fcsm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .CONT_CODE(CONT)) flash (
      .addr(flashAddr), .dq(flashDqOut), .ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN),
      .resetN(flashResetN), .byteN(flashByteN), .guardN(guardN), .failMode(failMode),
      .dqIn(flashDqIn), .readyBusyN(flashReadyBusyN));
   // ==========================================
   // register port tasks
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdata; // data stands only this cycle
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // order one operation, then poll busy under a bound
   task automatic op(input fcsm_op_e o, input logic [19:0] a, input logic [16:0] d);
      int n;
      wr(`FCSM_REG_ADDR, {12'h000, a});
      wr(`FCSM_REG_DATA, {15'h0000, d});
      wr(`FCSM_REG_CMD, {28'h0000000, o});
      n = 0;
      do begin
         rd(`FCSM_REG_STATUS, rv);
         n++;
      end while (rv[0] !== 1'b0 && n < 500);
      if (n >= 500) chk("busy wait", 32'h0, rv);
   endtask
   task automatic rdf(input logic [19:0] a, input logic [15:0] exp);
      op(FCSM_OP_READ, a, 17'h00000);
      rd(`FCSM_REG_RDATA, rv);
      chk("flash read", {16'h0000, exp}, rv);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================
   // test sequence
   initial begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("ce idle", 32'h1, {31'h0, flashCeN});
      rd(`FCSM_REG_STATUS, rv);
      chk("status", 32'h4, rv);
      rdf(20'h00005, 16'hFFFF);
      $display("test reset done");
      op(FCSM_OP_PROG, 20'h00005, 17'h01234);
      rdf(20'h00005, 16'h1234);
      op(FCSM_OP_PROG, 20'h00005, 17'h00230);
      rdf(20'h00005, 16'h0230);
      $display("test program done");
      op(FCSM_OP_IDENT, 20'h00000, 17'h00000);
      rdf(20'h00100, MFR);
      rdf(20'h00001, DEV);
      rdf(20'h00011, CONT);
      rdf(20'h00002, 16'h0000);
      rdf(20'hF8002, 16'h0000);
      guardN <= 1'b0;
      rdf(20'hF8002, 16'h0001);
      op(FCSM_OP_RESET, 20'h00000, 17'h00000);
      rdf(20'h00005, 16'h0230);
      $display("test identification done");
      op(FCSM_OP_BYP_ENTER, 20'h00000, 17'h00000);
      op(FCSM_OP_BYP_PROG, 20'h00006, 17'h00055);
      op(FCSM_OP_BYP_EXIT, 20'h00000, 17'h00000);
      rdf(20'h00006, 16'h0055);
      $display("test bypass done");
      op(FCSM_OP_CHIP_ERASE, 20'h00000, 17'h0FFFF);
      rdf(20'h00005, 16'hFFFF);
      $display("test erase done");
      failMode <= 1'b1;
      op(FCSM_OP_PROG, 20'h00007, 17'h00012);
      chk("timeout error", 32'h2, rv & 32'h2);
      failMode <= 1'b0;
      rdf(20'h00007, 16'hFFFF);
      $display("test timeout done");
      wr(`FCSM_REG_ADDR, 32'h00008);
      wr(`FCSM_REG_DATA, 32'h00011);
      wr(`FCSM_REG_CMD, {28'h0000000, FCSM_OP_PROG});
      repeat (25) @(posedge mclk);
      reset <= 1'b1;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      op(FCSM_OP_PROG, 20'h00008, 17'h00011);
      rdf(20'h00008, 16'h0011);
      $display("test hardware reset done");
      final_report();
   end
   initial begin
      #400000;
      n_errors++;
      $display("ERROR watchdog expected done seen hang");
      final_report();
   end
endmodule
`default_nettype wire
